// File: pvt_video_source.sv
// Behaviour
// - Frame sync high at least one line
// - Back porch at least two lines
// - Front porch at least one line
// - Vertical blanking six plus eight times ratio
// - Line sync width four to 128 clocks
// - Four clocks line sync to strobe
// - Eight clocks strobe end to sync
// - Horizontal blanking from clock and line rate; code checks only back plus front porch minimum (12 clocks)
// - Too little blanking flags configuration invalid
// - Capture edge selectable, data launched opposite
// - Reset held low at least 1.25 us
//
// Parallel video source that drives the display controller's pixel port.
// Assumes a pixel clock made here by dividing clk; timing fields are
// static inputs, changed only while run is low.
`timescale 1ns/1ps
module pvt_video_source
    import pvt_pkg::*;
#(
    parameter int unsigned PCLK_DIV = 2,
    parameter int unsigned RST_CYC  = RESET_LOW_CYC
)
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Control
    input  wire logic             run,
    input  wire logic             resetReq,
    input  wire logic             captureFalling,
    input  wire logic [CNT_W-1:0] activePixelsPerLine,
    input  wire logic [CNT_W-1:0] totalPixelsPerLine,
    input  wire logic [CNT_W-1:0] hsyncWidth,
    input  wire logic [CNT_W-1:0] hBackPorch,
    input  wire logic [CNT_W-1:0] sourceActiveLines,
    input  wire logic [CNT_W-1:0] arrayUsedLines,
    input  wire logic [CNT_W-1:0] vsyncLines,
    input  wire logic [CNT_W-1:0] vBackPorch,
    input  wire logic [CNT_W-1:0] vFrontPorch,
    input  wire logic [PIX_W-1:0] pixelSeed,
    // Status
    output logic                  configBad_q,
    output logic                  frameDone_q,
    output logic [CNT_W-1:0]      pixelsSent_q,
    // Device pins
    output logic                  extResetLow_q,
    output logic                  pixelClock_q,
    output logic                  frameSync_q,
    output logic                  lineSync_q,
    output logic                  activePixelStrobe_q,
    output logic [PIX_W-1:0]      pixelBus_q
);
    typedef enum logic [1:0] {PVT_IDLE, PVT_RUN} pvt_state_e;

    // Configuration check, run on clk
    logic [CNT_W-1:0] hBlank;
    logic [CNT_W-1:0] hFront;
    logic [CNT_W+3:0] vBlankMin;
    logic [CNT_W:0]   vBlank;
    logic             cfgBad;

    always_comb
    begin
        hBlank = totalPixelsPerLine - activePixelsPerLine;
        hFront = hBlank - hBackPorch;
        vBlank = {1'b0, vBackPorch} + {1'b0, vFrontPorch};
        // Ratio max(1, src/array), rounded up so blanking never short
        if (arrayUsedLines == '0 || sourceActiveLines <= arrayUsedLines)
            vBlankMin = (CNT_W+4)'(TVB_BASE + TVB_SCALE);
        else
            vBlankMin = (CNT_W+4)'(TVB_BASE) + (CNT_W+4)'(TVB_SCALE) *
                (CNT_W+4)'((sourceActiveLines + arrayUsedLines - 1'b1)
                / arrayUsedLines);
        cfgBad = (totalPixelsPerLine <= activePixelsPerLine)
            || (hBlank < CNT_W'(HBP_MIN + HFP_MIN))
            || (hsyncWidth < CNT_W'(HSW_MIN))
            || (hsyncWidth > CNT_W'(HSW_MAX))
            || (hBackPorch < CNT_W'(HBP_MIN))
            || (hBackPorch < hsyncWidth)
            || (hFront < CNT_W'(HFP_MIN))
            || (vsyncLines < CNT_W'(VSYNC_LINES_MIN))
            || (vBackPorch < CNT_W'(VBP_LINES_MIN))
            || (vBackPorch < vsyncLines)
            || (vFrontPorch < CNT_W'(VFP_LINES_MIN))
            || ({3'b000, vBlank} < vBlankMin)
            || (sourceActiveLines == '0);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            configBad_q <= 1'b0;
        else
            configBad_q <= cfgBad;
    end

    // Device reset pulse
    logic resetBusy;
    pvt_reset_gen #(.LOW_CYC(RST_CYC)) uResetGen (
        .clk           (clk),
        .rst           (rst),
        .start         (resetReq),
        .extResetLow_q (extResetLow_q),
        .busy_q        (resetBusy)
    );

    // Pixel clock from divider; no second domain on this end
    logic [7:0] divCnt_q;
    logic       pixTick;
    assign pixTick = (divCnt_q == 8'(PCLK_DIV - 1));

    always_ff @(posedge clk)
    begin
        if (rst || pixTick)
            divCnt_q <= 8'h00;
        else
            divCnt_q <= divCnt_q + 8'h01;
    end

    // Half-period toggles; launch on the edge opposite the capture edge
    logic launch;
    logic halfTick;
    assign halfTick = (divCnt_q == 8'(PCLK_DIV/2 - 1));
    always_ff @(posedge clk)
    begin
        if (rst)
            pixelClock_q <= 1'b0;
        else if (pixTick || halfTick)
            pixelClock_q <= ~pixelClock_q;
    end
    // Either toggle may launch: the one that leaves the capture level
    assign launch = (pixTick || halfTick) &&
        (captureFalling ? !pixelClock_q : pixelClock_q);

    // Raster state
    pvt_state_e       state_q;
    logic [CNT_W-1:0] hCnt_q;
    logic [CNT_W-1:0] vCnt_q;
    logic [CNT_W-1:0] vTotal;
    logic             lineEnd;
    logic             frameEnd;
    logic             vActive;
    logic             hActive;

    assign vTotal   = vBackPorch + sourceActiveLines + vFrontPorch;
    assign lineEnd  = (hCnt_q == totalPixelsPerLine - 1'b1);
    assign frameEnd = lineEnd && (vCnt_q == vTotal - 1'b1);
    // Line 0 starts with frame sync; active lines follow the back porch
    assign vActive  = (vCnt_q >= vBackPorch) &&
        (vCnt_q < vBackPorch + sourceActiveLines);
    assign hActive  = (hCnt_q >= hBackPorch) &&
        (hCnt_q < hBackPorch + activePixelsPerLine);

    always_ff @(posedge clk)
    begin
        if (rst)
            state_q <= PVT_IDLE;
        else
        begin
            case (state_q)
                PVT_IDLE:
                    // Config frozen across a frame; bad timing never leaves
                    if (run && !cfgBad && !resetBusy && launch)
                        state_q <= PVT_RUN;
                PVT_RUN:
                    if (launch && frameEnd && (!run || cfgBad))
                        state_q <= PVT_IDLE;
                default:
                    state_q <= PVT_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst || state_q != PVT_RUN)
        begin
            hCnt_q <= '0;
            vCnt_q <= '0;
        end
        else if (launch)
        begin
            hCnt_q <= lineEnd ? '0 : hCnt_q + 1'b1;
            if (frameEnd)
                vCnt_q <= '0;
            else if (lineEnd)
                vCnt_q <= vCnt_q + 1'b1;
        end
    end

    // Pin drivers, updated only on the launch edge
    logic running;
    assign running = (state_q == PVT_RUN);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            frameSync_q         <= 1'b0;
            lineSync_q          <= 1'b0;
            activePixelStrobe_q <= 1'b0;
            pixelBus_q          <= PIX_RESET;
        end
        else if (launch)
        begin
            frameSync_q <= running && (vCnt_q < vsyncLines);
            lineSync_q  <= running && (hCnt_q < hsyncWidth);
            activePixelStrobe_q <= running && vActive && hActive;
            // Bus held at rest outside active pixels
            pixelBus_q  <= (running && vActive && hActive)
                ? pixelSeed + PIX_W'(hCnt_q - hBackPorch) : PIX_RESET;
        end
    end

    // Count pixels of the current line the device will accept
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pixelsSent_q <= '0;
            frameDone_q  <= 1'b0;
        end
        else
        begin
            frameDone_q <= launch && running && frameEnd;
            if (launch && lineSync_q == 1'b0 && hCnt_q == '0)
                pixelsSent_q <= '0;
            else if (launch && activePixelStrobe_q)
                pixelsSent_q <= pixelsSent_q + 1'b1;
        end
    end

    // Checks on the generated raster, counted in launch edges
    logic [CNT_W-1:0] hsRun_q;
    logic [CNT_W-1:0] sinceHs_q;
    logic [CNT_W-1:0] sinceDe_q;
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            hsRun_q   <= '0;
            sinceHs_q <= '0;
            sinceDe_q <= '1;
        end
        else if (launch)
        begin
            hsRun_q   <= lineSync_q ? hsRun_q + 1'b1 : '0;
            sinceHs_q <= (lineSync_q && hsRun_q == '0) ? 16'h0001
                : sinceHs_q + 1'b1;
            // Saturates so a long idle never wraps into a false edge
            if (activePixelStrobe_q)
                sinceDe_q <= '0;
            else if (sinceDe_q != '1)
                sinceDe_q <= sinceDe_q + 1'b1;
        end
    end

    // Vertical checks, counted in line sync leading edges
    logic             lsRise;
    logic             fsRise;
    logic             fsFall;
    logic             deRise;
    logic             fsPrev_q;
    logic             activeSeen_q;
    logic             prevActive_q;
    logic [CNT_W-1:0] linesSinceFs_q;
    logic [CNT_W-1:0] linesSinceDe_q;
    assign lsRise = launch && lineSync_q && hsRun_q == '0;
    assign fsRise = launch && frameSync_q && !fsPrev_q;
    assign fsFall = launch && !frameSync_q && fsPrev_q;
    assign deRise = launch && activePixelStrobe_q && sinceDe_q != '0;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            fsPrev_q     <= 1'b0;
            activeSeen_q <= 1'b0;
            prevActive_q <= 1'b0;
        end
        else if (launch)
        begin
            fsPrev_q <= frameSync_q;
            if (fsRise)
            begin
                activeSeen_q <= 1'b0;
                prevActive_q <= activeSeen_q;
            end
            else if (deRise)
                activeSeen_q <= 1'b1;
        end
    end

    // Line 0 counts on the launch that raises frame sync
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            linesSinceFs_q <= '0;
            linesSinceDe_q <= '0;
        end
        else
        begin
            if (fsRise)
                linesSinceFs_q <= lsRise ? 16'h0001 : 16'h0000;
            else if (lsRise)
                linesSinceFs_q <= linesSinceFs_q + 1'b1;
            if (deRise)
                linesSinceDe_q <= '0;
            else if (lsRise)
                linesSinceDe_q <= linesSinceDe_q + 1'b1;
        end
    end

    sequence s_frameStart;
        fsRise && activeSeen_q;
    endsequence
    sequence s_firstActive;
        deRise && !activeSeen_q;
    endsequence

    sequence s_hsFall;
        launch && !lineSync_q && hsRun_q != '0;
    endsequence

    a_hsync_width: assert property (@(posedge clk) disable iff (rst)
        launch && lineSync_q |-> hsRun_q < CNT_W'(HSW_MAX))
        else $error("line sync too long");
    a_hsync_min: assert property (@(posedge clk) disable iff (rst)
        s_hsFall |-> hsRun_q >= CNT_W'(HSW_MIN))
        else $error("line sync too short");
    a_back_porch: assert property (@(posedge clk) disable iff (rst)
        launch && activePixelStrobe_q && sinceDe_q != '0
        |-> sinceHs_q >= CNT_W'(HBP_MIN))
        else $error("strobe rose too soon after line sync");
    a_front_porch: assert property (@(posedge clk) disable iff (rst)
        launch && lineSync_q && hsRun_q == '0
        |-> sinceDe_q >= CNT_W'(HFP_MIN))
        else $error("line sync rose too soon after strobe");
    a_no_bad_run: assert property (@(posedge clk) disable iff (rst)
        state_q == PVT_IDLE && cfgBad |=> state_q == PVT_IDLE)
        else $error("started with invalid timing");
    a_vs_not_active: assert property (@(posedge clk) disable iff (rst)
        frameSync_q |-> !activePixelStrobe_q)
        else $error("active pixels during frame sync");
    a_launch_edge: assert property (@(posedge clk) disable iff (rst)
        launch |=> pixelClock_q == captureFalling)
        else $error("data launched on the capture edge");
    a_pix_count: assert property (@(posedge clk) disable iff (rst)
        launch && activePixelStrobe_q |=> pixelsSent_q != '0)
        else $error("accepted pixel not counted");
    a_vsync_width: assert property (@(posedge clk) disable iff (rst)
        fsFall |-> linesSinceFs_q >= CNT_W'(VSYNC_LINES_MIN))
        else $error("frame sync shorter than a line");
    a_vert_back: assert property (@(posedge clk) disable iff (rst)
        s_firstActive |-> linesSinceFs_q > CNT_W'(VBP_LINES_MIN))
        else $error("vertical back porch too short");
    a_vert_front: assert property (@(posedge clk) disable iff (rst)
        s_frameStart |-> linesSinceDe_q >= CNT_W'(VFP_LINES_MIN))
        else $error("vertical front porch too short");
    a_vert_blank: assert property (@(posedge clk) disable iff (rst)
        deRise && !activeSeen_q && prevActive_q
        |-> {4'h0, linesSinceDe_q} > vBlankMin)
        else $error("vertical blanking too short");
endmodule : pvt_video_source

// File: pvt_pkg.sv
// Shared constants for the parallel video source (host side) design.
// Assumes a 200 MHz system clock and a pixel clock made by division of it.
package pvt_pkg;
    localparam int unsigned CLK_MHZ          = 200;
    localparam real         RESET_LOW_US     = 1.25;
    localparam int unsigned RESET_LOW_CYC    =
        int'($ceil(RESET_LOW_US * CLK_MHZ));
    localparam int unsigned VSYNC_LINES_MIN  = 1;
    localparam int unsigned VBP_LINES_MIN    = 2;
    localparam int unsigned VFP_LINES_MIN    = 1;
    localparam int unsigned TVB_BASE         = 6;
    localparam int unsigned TVB_SCALE        = 8;
    localparam int unsigned HSW_MIN          = 4;
    localparam int unsigned HSW_MAX          = 128;
    localparam int unsigned HBP_MIN          = 4;
    localparam int unsigned HFP_MIN          = 8;
    localparam int unsigned THB_SCALE        = 1000;
    localparam int unsigned PIX_W            = 24;
    localparam int unsigned CNT_W            = 16;
    localparam logic [PIX_W-1:0] PIX_RESET   = 24'h00_0000;
endpackage : pvt_pkg

// File: pvt_reset_gen.sv
// Active-low reset pulse generator for the display controller.
// Assumes a start pulse from logic on clk; holds the pin low long enough.
`timescale 1ns/1ps
module pvt_reset_gen
    import pvt_pkg::*;
#(
    parameter int unsigned LOW_CYC = RESET_LOW_CYC
)
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Control
    input  wire logic start,
    output logic      extResetLow_q,
    output logic      busy_q
);
    logic [CNT_W-1:0] cnt_q;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cnt_q         <= '0;
            extResetLow_q <= 1'b0;
            busy_q        <= 1'b1;
        end
        else if (start && !busy_q)
        begin
            cnt_q         <= '0;
            extResetLow_q <= 1'b0;
            busy_q        <= 1'b1;
        end
        else if (busy_q)
        begin
            if (cnt_q == CNT_W'(LOW_CYC - 1))
            begin
                extResetLow_q <= 1'b1;
                busy_q        <= 1'b0;
            end
            else
            begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

    logic [CNT_W-1:0] lowRun_q;
    always_ff @(posedge clk)
    begin
        if (rst || extResetLow_q)
            lowRun_q <= '0;
        else
            lowRun_q <= lowRun_q + 1'b1;
    end

    a_reset_low_width: assert property (@(posedge clk) disable iff (rst)
        $rose(extResetLow_q) |-> lowRun_q >= CNT_W'(LOW_CYC - 1))
        else $error("reset pulse released too early");
endmodule : pvt_reset_gen

// File: pvt_device_model.sv
// Receiving pixel port of the display controller, modelled behaviourally.
// Assumes host-side pins; reports measured timing and a violation count.
`timescale 1ns/1ps
module pvt_device_model
    import pvt_pkg::*;
(
    // Clocks
    input  wire logic             clk,
    input  wire logic             captureFalling,
    // Device pins
    input  wire logic             extResetLow,
    input  wire logic             pixelClock,
    input  wire logic             frameSync,
    input  wire logic             lineSync,
    input  wire logic             activePixelStrobe,
    input  wire logic [PIX_W-1:0] pixelBus,
    // Measurements
    output int                    rstLow,
    output int                    hsw,
    output int                    hbp,
    output int                    hfp,
    output int                    pix,
    output int                    vbp,
    output int                    lines,
    output int                    viol,
    output logic [PIX_W-1:0]      firstPix,
    output logic [PIX_W-1:0]      lastPix
);
    int   rc = 0, t = 0, tLs = 0, tDe = 0, li = 0, la = 0, ac = 0;
    logic ls0 = 0, de0 = 0, fs0 = 0, seen = 0, dn = 0;
    // Only the chosen edge samples; the source launches on the other
    wire  capClk = pixelClock ^ captureFalling;

    initial viol = 0;

    always @(posedge clk)
    begin
        if (!extResetLow)
            rc <= rc + 1;
        else if (rc != 0)
        begin
            rstLow <= rc;
            rc     <= 0;
        end
    end

    always @(posedge capClk)
    begin
        t = t + 1;
        if (frameSync && !fs0)
        begin
            if (seen && li - la < VFP_LINES_MIN) viol++;
            if (seen && vbp + li - la < TVB_BASE + TVB_SCALE) viol++;
            lines = ac;
            seen  = 1;
            ac    = 0;
            li    = -1;
        end
        if (lineSync && !ls0)
        begin
            li++;
            tLs = t;
            // Front porch only measured on a line that carried pixels
            if (dn)
            begin
                hfp = t - tDe;
                if (hfp < HFP_MIN) viol++;
            end
            dn = 0;
        end
        if (!frameSync && fs0 && li < VSYNC_LINES_MIN) viol++;
        if (!lineSync && ls0)
        begin
            hsw = t - tLs;
            if (hsw < HSW_MIN || hsw > HSW_MAX) viol++;
        end
        if (activePixelStrobe && !de0)
        begin
            hbp = t - tLs;
            if (hbp < HBP_MIN) viol++;
            if (ac == 0) vbp = li;
            if (ac == 0 && li < VBP_LINES_MIN) viol++;
            ac++;
            la       = li;
            pix      = 0;
            firstPix = pixelBus;
        end
        if (activePixelStrobe)
        begin
            pix++;
            lastPix = pixelBus;
        end
        if (!activePixelStrobe && de0)
        begin
            tDe = t;
            dn  = 1;
        end
        ls0 = lineSync;
        de0 = activePixelStrobe;
        fs0 = frameSync;
    end
endmodule : pvt_device_model

// File: pvt_video_source_tb.sv
// Self-checking bench for the parallel video source.
// Assumes the device model sits in the same folder.
`timescale 1ns/1ps
module pvt_video_source_tb;
    import pvt_pkg::*;
    localparam int RC = RESET_LOW_CYC;
    logic             clk = 0, rst = 1, run = 0, resetReq = 0, capF = 0;
    logic             sawPin = 0;
    logic [CNT_W-1:0] active_pixels_per_line = 16'h0008, tot, hs, hb, src, arr, vs, vb, vf;
    logic [PIX_W-1:0] seed = 24'h12_3456;
    wire              cfgBad, fDone, rstPin, pclk, fs, ls, de;
    wire  [CNT_W-1:0] sent;
    wire  [PIX_W-1:0] bus, mFirst, mLast;
    int               mRst, mHsw, mHbp, mHfp, mPix, mVbp, mLines, mViol;
    int               n_fail = 0, cmp_count = 0, cyc = 0;

    always #2.5 clk = ~clk;

    pvt_video_source #(.PCLK_DIV(2), .RST_CYC(RC)) u_pvt_video_source (
        .clk(clk), .rst(rst), .run(run), .resetReq(resetReq),
        .captureFalling(capF), .activePixelsPerLine(active_pixels_per_line),
        .totalPixelsPerLine(tot), .hsyncWidth(hs), .hBackPorch(hb),
        .sourceActiveLines(src), .arrayUsedLines(arr), .vsyncLines(vs),
        .vBackPorch(vb), .vFrontPorch(vf), .pixelSeed(seed),
        .configBad_q(cfgBad), .frameDone_q(fDone), .pixelsSent_q(sent),
        .extResetLow_q(rstPin), .pixelClock_q(pclk), .frameSync_q(fs),
        .lineSync_q(ls), .activePixelStrobe_q(de), .pixelBus_q(bus));

    pvt_device_model u_pvt_device_model (
        .clk(clk), .captureFalling(capF), .extResetLow(rstPin),
        .pixelClock(pclk), .frameSync(fs), .lineSync(ls),
        .activePixelStrobe(de), .pixelBus(bus), .rstLow(mRst),
        .hsw(mHsw), .hbp(mHbp), .hfp(mHfp), .pix(mPix), .vbp(mVbp),
        .lines(mLines), .viol(mViol), .firstPix(mFirst), .lastPix(mLast));

    always @(posedge clk)
    begin
        if (fs | ls | de) sawPin <= 1'b1;
        cyc++;
        if (cyc == 40000)
        begin
            n_fail++;
            results();
        end
    end

    task automatic results;
        if (n_fail == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %0t got %0d expected %0d", $time, got, exp);
        end
    endtask : check

    task automatic checkBit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %0t flag mismatch", $time);
        end
    endtask : checkBit

    // Settings inside every limit, one blanking line to spare nowhere
    task automatic goodCfg;
        tot = 16'h0014;
        hs  = 16'h0004;
        hb  = 16'h0004;
        src = 16'h0004;
        arr = 16'h0004;
        vs  = 16'h0001;
        vb  = 16'h0002;
        vf  = 16'h000C;
    endtask : goodCfg

    task automatic waitRst(input logic lvl);
        int n;
        n = 0;
        while (rstPin !== lvl && n < 400)
        begin
            @(negedge clk);
            n++;
        end
        repeat (2) @(negedge clk);
        checkBit(rstPin, lvl);
    endtask : waitRst

    task automatic waitFrame;
        int n;
        n = 0;
        @(negedge clk);
        while (fDone !== 1'b1 && n < 4000)
        begin
            @(negedge clk);
            n++;
        end
        checkBit(fDone, 1'b1);
    endtask : waitFrame

    // A line never stays quiet for 100 clocks while a frame is running
    task automatic waitIdle;
        int n, q;
        n = 0;
        q = 0;
        while (q < 100 && n < 4000)
        begin
            @(negedge clk);
            q = (fs | ls | de) ? 0 : q + 1;
            n++;
        end
        check(q, 100);
    endtask : waitIdle

    task automatic devReset;
        waitRst(1'b1);
        check(int'(mRst >= RC), 1);
        resetReq = 1'b1;
        @(negedge clk);
        resetReq = 1'b0;
        waitRst(1'b0);
        waitRst(1'b1);
        check(int'(mRst >= RC && mRst <= RC + 2), 1);
    endtask : devReset

    task automatic frames(input logic f);
        capF = f;
        run  = 1'b1;
        while (de !== 1'b1) @(negedge clk);
        while (de === 1'b1) @(negedge clk);
        check(sent, active_pixels_per_line);
        repeat (3) waitFrame();
        run = 1'b0;
        waitIdle();
        check(mHsw, hs);
        check(mHbp, hb);
        check(mHfp, tot - hb - active_pixels_per_line);
        check(mPix, active_pixels_per_line);
        check(mVbp, vb);
        check(mLines, src);
        check(mViol, 0);
        checkBit(mFirst === seed, 1'b1);
        checkBit(mLast === seed + 24'(active_pixels_per_line) - 24'h00_0001, 1'b1);
    endtask : frames

    task automatic badCfg;
        for (int i = 0; i < 10; i++)
        begin
            case (i)
                0: hs = 16'h0003;
                1: hs = 16'h0081;
                2: hb = 16'h0003;
                3: tot = 16'h0013;
                4: tot = active_pixels_per_line;
                5: vs = 16'h0000;
                6: vb = 16'h0001;
                7: vf = 16'h0000;
                8: vf = 16'h000B;
                default: src = 16'h0008;
            endcase
            repeat (4) @(negedge clk);
            checkBit(cfgBad, 1'b1);
            sawPin = 1'b0;
            run    = 1'b1;
            repeat (200) @(negedge clk);
            checkBit(sawPin, 1'b0);
            run = 1'b0;
            goodCfg();
            repeat (4) @(negedge clk);
            checkBit(cfgBad, 1'b0);
        end
    endtask : badCfg

    initial
    begin
        goodCfg();
        repeat (12) @(negedge clk);
        rst = 1'b0;
        devReset();
        frames(1'b0);
        frames(1'b1);
        badCfg();
        results();
    end
endmodule : pvt_video_source_tb
